// ===== core/stack_pointer_limit_check.sv
// software stack pointer, push/pop addressing, pc formatting and stack error trap
// assumes requests come from core logic on clk; memory answers are not awaited
`timescale 1ns/1ps
`default_nettype none
module stack_pointer_limit_check
  import stack_check_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              pushReq,
  input  wire push_kind_t        pushKind,
  input  wire logic [15:0]       pushData,
  input  wire logic [PC_W-1:0]   pcValue,
  input  wire logic [7:0]        statusLowByte,
  input  wire logic              popReq,
  input  wire logic              spWrite,
  input  wire logic [15:0]       spWdata,
  input  wire logic              limWrite,
  input  wire logic [15:0]       limWdata,
  input  wire logic              extEaValid,
  input  wire logic              extEaWrite,
  input  wire logic [15:0]       extEaAddr,
  output logic                   ready,
  output logic [15:0]            stackPointer,
  output logic [15:0]            stackLimit,
  output logic [15:0]            memAddr,
  output logic [15:0]            memWdata,
  output logic                   memWe,
  output logic                   memRe,
  output logic                   stackErr
);
  seq_state_t  state_q;
  seq_state_t  state_d;
  logic [15:0] sp_q;
  logic [15:0] lim_q;
  logic [15:0] hiWord_q;
  logic [15:0] memAddr_q;
  logic [15:0] memWdata_q;
  logic        memWe_q;
  logic        memRe_q;
  logic        err_q;
  logic        pushGo;
  logic        popGo;
  logic        hiGo;
  logic        accOver;
  logic        accUnder;
  logic        extOver;
  logic        extUnder;
  logic [15:0] accAddr;
  logic        accIsPush;

  // word-aligned form of a byte address
  function automatic logic [15:0] align_word(input logic [15:0] a);
    return {a[15:1], ALIGN_ZERO};
  endfunction

  // upper word of a pc push, top byte chosen by push kind
  function automatic logic [15:0] pc_upper(input push_kind_t k, input logic [PC_W-1:0] pc,
                                           input logic [7:0] statusByte);
    logic [7:0] top;
    top = ZERO_BYTE;
    if (k == KIND_EXC) begin
      top = statusByte;
    end
    return {top, ZERO_BYTE[0], pc[PC_W-1:PC_HI_LSB]};
  endfunction

  // request acceptance; pointer load wins over stack traffic
  assign ready  = (state_q == ST_IDLE) && !spWrite;
  assign pushGo = ready && pushReq;
  assign popGo  = ready && popReq && !pushReq;
  assign hiGo   = (state_q == ST_PC_HI);

  // address of the access made this cycle: push at sp, pop at sp minus a word
  assign accIsPush = pushGo || hiGo;
  assign accAddr   = popGo ? (sp_q - WORD_STEP) : sp_q;

  // limit and lower bound comparison for own accesses and core addresses
  stack_bound_check accCheck (
    .eaAddr    (accAddr),
    .eaIsPush  (accIsPush),
    .limitVal  (lim_q),
    .overflow  (accOver),
    .underflow (accUnder)
  );
  stack_bound_check extCheck (
    .eaAddr    (extEaAddr),
    .eaIsPush  (extEaWrite),
    .limitVal  (lim_q),
    .overflow  (extOver),
    .underflow (extUnder)
  );

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pushGo && (pushKind != KIND_DATA)) begin
          state_d = ST_PC_HI;
        end
      end
      ST_PC_HI: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // stack pointer: next free word, two bytes per step
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_q <= SP_RESET;
    end else if (spWrite) begin
      sp_q <= align_word(spWdata);
    end else if (pushGo || hiGo) begin
      sp_q <= sp_q + WORD_STEP;
    end else if (popGo) begin
      sp_q <= sp_q - WORD_STEP;
    end
  end

  // stack limit: deliberately left without reset, bit 0 held clear
  always_ff @(posedge clk) begin
    if (limWrite) begin
      lim_q <= align_word(limWdata);
    end
  end

  // upper pc word kept for the second push cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiWord_q <= 16'h0000;
    end else if (pushGo && (pushKind != KIND_DATA)) begin
      hiWord_q <= pc_upper(pushKind, pcValue, statusLowByte);
    end
  end

  // registered memory request, low pc word goes first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memAddr_q  <= 16'h0000;
      memWdata_q <= 16'h0000;
      memWe_q    <= 1'b0;
      memRe_q    <= 1'b0;
    end else begin
      memWe_q <= pushGo || hiGo;
      memRe_q <= popGo;
      if (pushGo || hiGo || popGo) begin
        memAddr_q <= accAddr;
      end
      if (hiGo) begin
        memWdata_q <= hiWord_q;
      end else if (pushGo) begin
        memWdata_q <= (pushKind == KIND_DATA) ? pushData : pcValue[15:0];
      end
    end
  end

  // stack error trap pulse; limit is used as stored, so a push in the same
  // cycle as a limit write is still checked against the old value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_q <= 1'b0;
    end else begin
      err_q <= ((pushGo || hiGo || popGo) && (accOver || accUnder))
               || (extEaValid && (extOver || extUnder));
    end
  end

  assign stackPointer = sp_q;
  assign stackLimit   = lim_q;
  assign memAddr      = memAddr_q;
  assign memWdata     = memWdata_q;
  assign memWe        = memWe_q;
  assign memRe        = memRe_q;
  assign stackErr     = err_q;

  // helper: limit has been written since the last reset, so compares see no X
  logic limKnown_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      limKnown_q <= 1'b0;
    end else if (limWrite) begin
      limKnown_q <= 1'b1;
    end
  end

  sequence s_data_push;
    pushGo && (pushKind == KIND_DATA);
  endsequence

  sequence s_pc_push(push_kind_t k);
    pushGo && (pushKind == k);
  endsequence

  chk_push_postinc: assert property (@(posedge clk) disable iff (!rstn)
    s_data_push |=> (memWe && memAddr == $past(sp_q) && sp_q == $past(sp_q) + WORD_STEP))
    else $error("push did not write at pointer then advance");

  chk_pop_predec: assert property (@(posedge clk) disable iff (!rstn)
    popGo |=> (memRe && memAddr == $past(sp_q) - WORD_STEP && sp_q == memAddr))
    else $error("pop did not predecrement pointer");

  chk_call_top_zero: assert property (@(posedge clk) disable iff (!rstn)
    s_pc_push(KIND_CALL) |=> ##1 (memWe && memWdata[15:8] == ZERO_BYTE))
    else $error("call pc push top byte not clear");

  chk_exc_top_status: assert property (@(posedge clk) disable iff (!rstn)
    s_pc_push(KIND_EXC) |=> ##1 (memWe && memWdata[15:8] == $past(statusLowByte, 2)))
    else $error("exception pc push top byte not status");

  chk_pc_two_words: assert property (@(posedge clk) disable iff (!rstn)
    s_pc_push(KIND_CALL) |=> !ready ##1 (sp_q == $past(sp_q, 2) + WORD_STEP + WORD_STEP))
    else $error("pc push did not take two words");

  chk_limit_even: assert property (@(posedge clk) disable iff (!rstn)
    limKnown_q |-> (stackLimit[0] == ALIGN_ZERO))
    else $error("limit bit 0 not zero");

  chk_sp_even: assert property (@(posedge clk) disable iff (!rstn)
    stackPointer[0] == ALIGN_ZERO)
    else $error("stack pointer misaligned");

  chk_at_limit_ok: assert property (@(posedge clk) disable iff (!rstn)
    (s_data_push and (sp_q == lim_q) and (sp_q >= SFR_TOP) and !extEaValid) |=> !stackErr)
    else $error("push at limit raised error");

  chk_beyond_limit: assert property (@(posedge clk) disable iff (!rstn)
    (s_data_push and limKnown_q and (sp_q > lim_q)) |=> stackErr)
    else $error("push beyond limit missed error");

  chk_underflow: assert property (@(posedge clk) disable iff (!rstn)
    (popGo && (sp_q - WORD_STEP < SFR_TOP)) |=> stackErr)
    else $error("underflow missed error");

  chk_ext_compare: assert property (@(posedge clk) disable iff (!rstn)
    (extEaValid && extEaWrite && limKnown_q && extEaAddr > lim_q) |=> stackErr)
    else $error("core address beyond limit missed error");
endmodule
`default_nettype wire

// ===== common/stack_check_pkg.sv
// constants and types shared by the stack pointer and limit check logic
// assumes a 16-bit data space addressed in bytes, stack words on even addresses
package stack_check_pkg;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned PC_W       = 23;
  localparam int unsigned BYTE_W     = 8;
  localparam logic [15:0] WORD_STEP  = 16'h0002; // one stack word in byte addresses
  localparam logic [15:0] SFR_TOP    = 16'h0800; // lowest legal stack address
  localparam logic [15:0] SP_RESET   = 16'h0800; // pointer value after reset
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam int unsigned PC_HI_LSB  = 16;      // first pc bit of the upper word
  localparam logic        ALIGN_ZERO = 1'b0;    // forced value of address bit 0

  // what a push carries
  typedef enum logic [1:0] {
    KIND_DATA = 2'h0,
    KIND_CALL = 2'h1,
    KIND_EXC  = 2'h2
  } push_kind_t;

  // push sequencer, gray along idle -> upper word -> idle
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PC_HI = 2'h1
  } seq_state_t;
endpackage

// ===== core/stack_bound_check.sv
// bound comparison of one stack effective address
// assumes limit bit 0 is already cleared by the caller
`timescale 1ns/1ps
`default_nettype none
module stack_bound_check
  import stack_check_pkg::*;
(
  input  wire logic [15:0] eaAddr,
  input  wire logic        eaIsPush,
  input  wire logic [15:0] limitVal,
  output logic             overflow,
  output logic             underflow
);
  // a push at the limit itself is legal, one beyond it is not
  assign overflow  = eaIsPush && (eaAddr > limitVal);
  // keep the stack out of the special register region
  assign underflow = eaAddr < SFR_TOP;
endmodule
`default_nettype wire

// ===== testbench/core_stack_partner.sv
// partner model: data memory beside the stack block, answers pushes and pops
// assumes stack words below byte address 0800h+2k and the same clock as the block
`timescale 1ns/1ps
`default_nettype none
module core_stack_partner (
  input  wire logic        clk,
  input  wire logic        memWe,
  input  wire logic        memRe,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic      [15:0] rdData
);
  logic [15:0] mem [0:1023];
  // store each pushed word at its word address
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memAddr[10:1]] <= memWdata;
    end
  end
  // answer only during a pop, otherwise show the inverse of the last written word
  assign rdData = memRe ? mem[memAddr[10:1]] : ~memWdata;
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the stack pointer and limit check block
// assumes one 10 MHz clock and the memory partner in core_stack_partner
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import stack_check_pkg::*;
;
  logic            clk, rstn, pushReq, popReq, spWrite, limWrite, extEaValid, extEaWrite;
  push_kind_t      pushKind;
  logic [15:0]     pushData, spWdata, limWdata, extEaAddr, rdData;
  logic [PC_W-1:0] pcValue;
  logic [7:0]      statusLowByte;
  logic            ready, memWe, memRe, stackErr;
  logic [15:0]     stackPointer, stackLimit, memAddr, memWdata;
  int              miscompares = 0;
  int              numChecks = 0;

  stack_pointer_limit_check stack_pointer_limit_check_inst (
    .clk, .rstn, .pushReq, .pushKind, .pushData, .pcValue, .statusLowByte, .popReq,
    .spWrite, .spWdata, .limWrite, .limWdata, .extEaValid, .extEaWrite, .extEaAddr,
    .ready, .stackPointer, .stackLimit, .memAddr, .memWdata, .memWe, .memRe, .stackErr
  );
  core_stack_partner core_stack_partner_inst (
    .clk, .memWe, .memRe, .memAddr, .memWdata, .rdData
  );

  // clock
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    if (miscompares == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // step to just after the next rising edge
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic load_sp(input logic [15:0] v);
    spWrite = 1'b1;
    spWdata = v | 16'h0001;
    cyc();
    spWrite = 1'b0;
    chk("sp load", v, stackPointer);
  endtask

  task automatic t_reset;
    chk("sp reset", SP_RESET, stackPointer);
    limWrite = 1'b1;
    limWdata = 16'h0901;
    cyc();
    limWrite = 1'b0;
    chk("limit bit0", 16'h0900, stackLimit);
    cyc();
  endtask

  // push then two pops back to back, the second one under the floor
  task automatic t_push_pop;
    load_sp(16'h0800);
    pushReq = 1'b1;
    pushKind = KIND_DATA;
    pushData = 16'hbeef;
    cyc();
    pushReq = 1'b0;
    popReq = 1'b1;
    chk("push we", 16'h0001, {15'h0, memWe});
    chk("push addr", 16'h0800, memAddr);
    chk("push data", 16'hbeef, memWdata);
    chk("push sp", 16'h0802, stackPointer);
    cyc();
    chk("pop addr", 16'h0800, memAddr);
    chk("pop data", 16'hbeef, rdData);
    chk("pop trap", 16'h0000, {15'h0, stackErr});
    chk("pop re", 16'h0001, {15'h0, memRe});
    cyc();
    popReq = 1'b0;
    chk("under addr", 16'h07fe, memAddr);
    chk("under trap", 16'h0001, {15'h0, stackErr});
  endtask

  // two-word pc push with the given top byte
  task automatic t_pc(input push_kind_t k, input logic [7:0] top);
    load_sp(16'h0800);
    pushReq = 1'b1;
    pushKind = k;
    pcValue = 23'h7abcde;
    statusLowByte = 8'h5a;
    cyc();
    pushReq = 1'b0;
    chk("pc busy", 16'h0000, {15'h0, ready});
    chk("pc lo", 16'hbcde, memWdata);
    chk("pc lo addr", 16'h0800, memAddr);
    cyc();
    chk("pc hi", {top, 8'h7a}, memWdata);
    chk("pc hi addr", 16'h0802, memAddr);
    chk("pc sp", 16'h0804, stackPointer);
  endtask

  // push at the limit passes, the next one traps
  task automatic t_limit_edge;
    load_sp(16'h0900);
    pushReq = 1'b1;
    popReq = 1'b1; // push wins over a pop in the same cycle
    pushKind = KIND_DATA;
    pushData = 16'h1234;
    cyc();
    chk("at limit", 16'h0000, {15'h0, stackErr});
    cyc();
    pushReq = 1'b0;
    popReq = 1'b0;
    chk("push wins", 16'h0000, {15'h0, memRe});
    chk("past limit", 16'h0001, {15'h0, stackErr});
    chk("past addr", 16'h0902, memAddr);
  endtask

  task automatic ext(input logic w, input logic [15:0] a, input logic e);
    extEaValid = 1'b1;
    extEaWrite = w;
    extEaAddr = a;
    cyc();
    extEaValid = 1'b0;
    chk("ext trap", {15'h0, e}, {15'h0, stackErr});
  endtask

  // mid-run reset: pointer returns to its reset value, limit keeps its contents
  task automatic t_midreset;
    rstn = 1'b0;
    cyc();
    rstn = 1'b1;
    chk("rst sp", SP_RESET, stackPointer);
    chk("rst limit", 16'h0900, stackLimit);
    pushReq = 1'b1;
    pushKind = KIND_DATA;
    pushData = 16'h0f0f;
    cyc();
    pushReq = 1'b0;
    chk("rst push addr", SP_RESET, memAddr);
    chk("rst push data", 16'h0f0f, memWdata);
    chk("rst push err", 16'h0000, {15'h0, stackErr});
  endtask

  // main sequence
  initial begin
    {clk, rstn, pushReq, popReq, spWrite, limWrite, extEaValid, extEaWrite} = '0;
    pushKind = KIND_DATA;
    {pushData, spWdata, limWdata, extEaAddr, statusLowByte} = '0;
    pcValue = '0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_push_pop();
    t_pc(KIND_CALL, 8'h00);
    t_pc(KIND_EXC, 8'h5a);
    t_limit_edge();
    ext(1'b1, 16'h0902, 1'b1);
    ext(1'b0, 16'h0902, 1'b0);
    ext(1'b1, 16'h0900, 1'b0);
    ext(1'b0, 16'h07fe, 1'b1);
    ext(1'b1, 16'h0800, 1'b0);
    t_midreset();
    test_done();
  end

  // watchdog, far beyond the few dozen cycles the tests take
  initial begin
    #200000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
